//--- rtl/rpf_ctrl.sv
// reset sequencing, cause flags, battery-backed trim and pin-float control
// Operation
// RULE1: watchdog timeout holds cpu in reset two machine cycles, then restarts at zero
// RULE2: watchdog timeout sets cause flag only while watchdog reset enable is one
// RULE3: software clears the cause flag after a watchdog reset
// RULE4: high reset pin is synchronous; needs running clock and two machine cycles
// RULE5: reset lasts while pin high; exit within two machine cycles, restart at zero
// RULE6: no external reset flag; external reset means neither power nor watchdog flag
// RULE7: reset pin in stop mode restarts oscillator, zeroes pc, waits full power delay
// RULE8: during any reset oscillator keeps running and nothing executes
// RULE9: resets never alter scratchpad or data memory contents
// RULE10: reset reinitialises stack pointer and disables interrupts and timers
// RULE11: every reset returns watchdog interval selection to shortest
// RULE12: reset sets all port latches to one within two machine cycles
// RULE13: battery-backed bits survive power-on reset; others keep or default
// RULE14: battery loss loads trim with 0110_0101; calendar bits left undefined
// RULE15: float entry: reset high, strobe low/high, release reset, hold strobes two cycles
// RULE16: float mode tristates ports, reset and access pins, pulls up strobes
// RULE17: port 2 bits 7..5 sampled only at reset fall; any low enters test mode
// RULE18: board must not drive port 2 bits 7..5 low while releasing reset
// RULE19: float mode ignores strobes; asserting reset returns to normal operation
// RULE20: power-on or power-fail reset sets the power-on flag
// RULE21: reset pin passes two flip-flops before use
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rpf_ctrl
	import rpf_pkg::*;
#(
	parameter int POR_DELAY = POR_DELAY_CLK
)
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic            pready,
	output logic            pslverr,
	input  wire logic       reset_pin,
	input  wire logic       ale_pin,
	input  wire logic       program_store_strobe,
	input  wire logic [2:0] port2_hi_pins,
	input  wire logic       power_fail,
	input  wire logic       battery_lost,
	input  wire logic       wdt_timeout,
	input  wire logic       stop_mode,
	output logic            core_reset,
	output logic            pc_load_zero,
	output logic            osc_enable,
	output logic            port_latch_set,
	output logic [1:0]      wdt_interval,
	output logic [7:0]      trim,
	output logic            test_mode,
	output logic            pin_float_mode,
	output logic            port_oe_n,
	output logic            reset_pin_oe_n,
	output logic            external_access_pin_oe_n,
	output logic            strobe_pullup_en
);
	localparam logic [CNT_W-1:0] DET_LAST = CNT_W'(DET_CYC - 1);
	localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_DELAY - 1);

	logic [SY_W-1:0]  sy;
	rpf_state_e       state;
	rpf_state_e       next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [3:0]       det_cnt;
	logic             hold_wdt;
	logic             next_hold_wdt;
	logic             pin_hi;
	logic             strobes_set;
	logic             det_done;
	logic             wdt_fire;
	logic             wd_reset_en;
	logic             wd_cause;
	logic             por_flag;
	logic             wr_en;
	logic             rd_en;
	logic [31:0]      rd_word;
	logic             rd_hit;

	function automatic logic in_reset(input rpf_state_e st);
		in_reset = (st != ST_RUN);
	endfunction : in_reset

	rpf_sync #(
		.WIDTH    (SY_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({battery_lost, power_fail, port2_hi_pins, program_store_strobe, ale_pin, reset_pin}),
		.sync_out (sy)
	); // [RULE21]

	assign pin_hi      = sy[SY_RST];
	assign strobes_set = !sy[SY_ALE] && sy[SY_PSS];
	assign det_done    = pin_hi && (det_cnt == 4'(DET_CYC - 1)); // [RULE4]
	assign wdt_fire    = wdt_timeout && wd_reset_en && (state == ST_RUN);

	// pin-high detection, counted only where the pin can start a reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			det_cnt <= 4'h0;
		else if (pin_hi && !det_done && (state == ST_RUN || state == ST_FLOAT))
			det_cnt <= det_cnt + 4'h1; // [RULE4]
		else
			det_cnt <= 4'h0;
	end

	always_comb
	begin
		next_state    = state;
		next_cnt      = cnt;
		next_hold_wdt = hold_wdt;
		if (sy[SY_POR])
		begin
			next_state = ST_WARM; // [RULE20]
			next_cnt   = '0;
		end
		else
		begin
			case (state)
				ST_RUN:
				begin
					if (stop_mode && pin_hi)
					begin
						next_state = ST_WARM; // [RULE7]
						next_cnt   = '0;
					end
					else if (det_done)
					begin
						next_state    = ST_HOLD; // [RULE4]
						next_hold_wdt = 1'b0;
						next_cnt      = '0;
					end
					else if (wdt_fire)
					begin
						next_state    = ST_HOLD; // [RULE1]
						next_hold_wdt = 1'b1;
						next_cnt      = '0;
					end
				end
				ST_HOLD:
				begin
					if (hold_wdt)
					begin
						next_cnt = cnt + 1'b1;
						if (pin_hi)
						begin
							next_hold_wdt = 1'b0;
							next_cnt      = '0;
						end
						else if (cnt == DET_LAST)
							next_state = ST_RUN; // [RULE1]
					end
					else if (!pin_hi)
					begin
						next_cnt   = '0;
						next_state = strobes_set ? ST_FENTRY : ST_EXIT; // [RULE5]
					end
				end
				ST_EXIT:
				begin
					next_cnt = cnt + 1'b1;
					if (pin_hi)
					begin
						next_state = ST_HOLD;
						next_cnt   = '0;
					end
					else if (cnt == DET_LAST)
						next_state = ST_RUN; // [RULE5]
				end
				ST_FENTRY:
				begin
					next_cnt = cnt + 1'b1;
					if (pin_hi)
					begin
						next_state = ST_HOLD;
						next_cnt   = '0;
					end
					else if (!strobes_set)
					begin
						next_state = ST_EXIT;
						next_cnt   = '0;
					end
					else if (cnt == DET_LAST)
						next_state = ST_FLOAT; // [RULE15]
				end
				ST_FLOAT:
				begin
					// strobes are no longer looked at here
					if (det_done)
					begin
						next_state    = ST_HOLD; // [RULE19]
						next_hold_wdt = 1'b0;
						next_cnt      = '0;
					end
				end
				ST_WARM:
				begin
					next_cnt = cnt + 1'b1;
					if (cnt == POR_LAST)
					begin
						next_cnt      = '0;
						next_hold_wdt = 1'b0;
						next_state    = pin_hi ? ST_HOLD : ST_RUN; // [RULE7]
					end
				end
				default:
				begin
					next_state = ST_HOLD;
					next_cnt   = '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state    <= ST_WARM;
			cnt      <= '0;
			hold_wdt <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			hold_wdt <= next_hold_wdt;
		end
	end

	// cpu-facing reset outputs; memories have no connection to this reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_reset     <= 1'b1;
			port_latch_set <= 1'b1;
			pc_load_zero   <= 1'b0;
			osc_enable     <= 1'b1;
		end
		else
		begin
			core_reset     <= in_reset(next_state); // [RULE8] [RULE9] [RULE10]
			port_latch_set <= in_reset(next_state); // [RULE12]
			pc_load_zero   <= (in_reset(state) && next_state == ST_RUN)
				|| (state == ST_RUN && next_state == ST_WARM); // [RULE1] [RULE5] [RULE7]
			osc_enable     <= in_reset(next_state) || !stop_mode; // [RULE8]
		end
	end

	// test-mode straps, caught at the falling edge of the reset pin only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			test_mode <= 1'b0;
		else if (state == ST_HOLD && !hold_wdt && !pin_hi && !sy[SY_POR])
			test_mode <= !(&sy[SY_P2LO +: 3]); // [RULE17]
	end

	// pin-float outputs; enables are low while the device drives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_float_mode           <= 1'b0;
			port_oe_n                <= 1'b0;
			reset_pin_oe_n           <= 1'b1;
			external_access_pin_oe_n <= 1'b1;
			strobe_pullup_en         <= 1'b0;
		end
		else
		begin
			pin_float_mode           <= (next_state == ST_FLOAT); // [RULE16]
			port_oe_n                <= (next_state == ST_FLOAT); // [RULE16]
			reset_pin_oe_n           <= 1'b1; // [RULE16]
			external_access_pin_oe_n <= 1'b1; // [RULE16]
			strobe_pullup_en         <= (next_state == ST_FLOAT); // [RULE16]
		end
	end

	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// watchdog control: flags are write-zero-to-clear, hardware set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wd_cause    <= 1'b0;
			wd_reset_en <= WD_EN_RESET;
		end
		else
		begin
			if (wr_en && paddr == OFS_WDCTL)
				wd_reset_en <= pwdata[WD_EN_BIT];
			if (wdt_fire) // [RULE6]
				wd_cause <= 1'b1; // [RULE2]
			else if (wr_en && paddr == OFS_WDCTL && !pwdata[WD_CAUSE_BIT])
				wd_cause <= 1'b0; // [RULE3]
		end
	end

	// power-on flag survives all but a power event; starts set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			por_flag <= 1'b1;
		else if (sy[SY_POR])
			por_flag <= 1'b1; // [RULE20]
		else if (wr_en && paddr == OFS_WDCTL && !pwdata[WD_POR_BIT])
			por_flag <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdt_interval <= WDSEL_SHORTEST;
		else if (in_reset(next_state))
			wdt_interval <= WDSEL_SHORTEST; // [RULE11]
		else if (wr_en && paddr == OFS_WDSEL)
			wdt_interval <= pwdata[1:0];
	end

	// trim is battery backed: power-on reset leaves it alone
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trim <= TRIM_DEFAULT;
		else if (sy[SY_BATT])
			trim <= TRIM_DEFAULT; // [RULE14]
		else if (wr_en && paddr == OFS_TRIM)
			trim <= pwdata[7:0]; // [RULE13]
	end

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (paddr)
			OFS_WDCTL:
			begin
				rd_word[WD_POR_BIT]   = por_flag;
				rd_word[WD_CAUSE_BIT] = wd_cause;
				rd_word[WD_EN_BIT]    = wd_reset_en;
			end
			OFS_TRIM:   rd_word[7:0] = trim;
			OFS_WDSEL:  rd_word[1:0] = wdt_interval;
			OFS_STATUS: rd_word[5:0] = {state, test_mode, pin_float_mode, core_reset};
			default:    rd_hit = 1'b0;
		endcase
	end

	// apb slave: no wait states, answer registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			if (rd_en)
				prdata <= rd_word;
			else if (psel && !penable)
				prdata <= 32'h0000_0000;
		end
	end
endmodule : rpf_ctrl
`default_nettype wire

//--- rtl/rpf_pkg.sv
// shared constants for the reset and pin-float controller
package rpf_pkg;
	// clock and machine-cycle timing
	localparam int          CLK_PERIOD_NS   = 5;
	localparam int          CLK_RATE_MHZ    = 1000 / CLK_PERIOD_NS;
	localparam int          MC_CLOCKS       = 4;
	localparam int          DET_MC          = 2;
	localparam int          DET_CYC         = DET_MC * MC_CLOCKS;
	localparam int          POR_DELAY_CLK   = 65536;
	localparam int          CNT_W           = 17;
	// register byte offsets
	localparam logic [7:0]  OFS_WDCTL       = 8'h00;
	localparam logic [7:0]  OFS_TRIM        = 8'h04;
	localparam logic [7:0]  OFS_WDSEL       = 8'h08;
	localparam logic [7:0]  OFS_STATUS      = 8'h0C;
	// watchdog_control_reg fields
	localparam int          WD_POR_BIT      = 6;
	localparam int          WD_CAUSE_BIT    = 2;
	localparam int          WD_EN_BIT       = 1;
	// reset values
	localparam logic [7:0]  TRIM_DEFAULT    = 8'h65;
	localparam logic [1:0]  WDSEL_SHORTEST  = 2'h0;
	localparam logic        WD_EN_RESET     = 1'b0;
	// synchronised pin vector layout
	localparam int          SY_RST          = 0;
	localparam int          SY_ALE          = 1;
	localparam int          SY_PSS          = 2;
	localparam int          SY_P2LO         = 3;
	localparam int          SY_POR          = 6;
	localparam int          SY_BATT         = 7;
	localparam int          SY_W            = 8;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_HOLD   = 3'b001,
		ST_EXIT   = 3'b011,
		ST_WARM   = 3'b010,
		ST_FENTRY = 3'b111,
		ST_FLOAT  = 3'b110
	} rpf_state_e;
endpackage : rpf_pkg

//--- rtl/rpf_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module rpf_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta     <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : rpf_sync
`default_nettype wire

//--- testbench/rpf_board.sv
// board model: reset source and emulator strobes
`timescale 1ns/100ps
`default_nettype none
module rpf_board
(
	input  wire logic       rst_req,
	input  wire logic       flt_req,
	input  wire logic       p2_low,
	output logic            reset_pin,
	output logic            ale_pin,
	output logic            program_store_strobe,
	output logic [2:0]      port2_hi_pins
);
	assign reset_pin = rst_req;
	// strobes held for float entry around the reset release
	assign ale_pin = !flt_req;
	assign program_store_strobe = flt_req;
	// undriven bits rest on their pull-ups
	assign port2_hi_pins = p2_low ? 3'h0 : 3'h7;
endmodule : rpf_board
`default_nettype wire

//--- testbench/rpf_ctrl_properties.sv
// port checker for the reset and pin-float controller
`timescale 1ns/100ps
`default_nettype none
module rpf_ctrl_properties
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       reset_pin,
	input wire logic       ale_pin,
	input wire logic       power_fail,
	input wire logic       battery_lost,
	input wire logic       core_reset,
	input wire logic       osc_enable,
	input wire logic       port_latch_set,
	input wire logic [1:0] wdt_interval,
	input wire logic [7:0] trim,
	input wire logic       pin_float_mode,
	input wire logic       port_oe_n,
	input wire logic       strobe_pullup_en,
	input wire logic       reset_pin_oe_n,
	input wire logic       external_access_pin_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_osc; core_reset |-> osc_enable; endproperty
	a_osc: assert property (p_osc) else $error("oscillator off in reset");
	property p_lat; port_latch_set == core_reset; endproperty
	a_lat: assert property (p_lat) else $error("port latches not set with reset");
	property p_intv; core_reset && $past(core_reset) |-> wdt_interval == 2'h0; endproperty
	a_intv: assert property (p_intv) else $error("interval not shortest in reset");
	property p_flt; pin_float_mode |-> port_oe_n && strobe_pullup_en; endproperty
	a_flt: assert property (p_flt) else $error("float pins wrong");
	property p_oen; reset_pin_oe_n && external_access_pin_oe_n; endproperty
	a_oen: assert property (p_oen) else $error("reset or access pin driven");
	property p_det; $rose(reset_pin) ##1 reset_pin[*8] |=> ##[0:6] core_reset; endproperty
	a_det: assert property (p_det) else $error("pin reset not entered");
	property p_exit; $fell(reset_pin) && ale_pin && !power_fail ##1 !reset_pin[*4] |-> ##[1:24] !core_reset; endproperty
	a_exit: assert property (p_exit) else $error("reset not left");
	property p_batt; battery_lost[*5] |-> trim == 8'h65; endproperty
	a_batt: assert property (p_batt) else $error("trim default not loaded");
	property p_ign; pin_float_mode && !reset_pin |=> pin_float_mode; endproperty
	a_ign: assert property (p_ign) else $error("float mode left without reset");
endmodule : rpf_ctrl_properties
bind rpf_ctrl rpf_ctrl_properties u_chk (.pclk, .presetn, .reset_pin, .ale_pin, .power_fail, .battery_lost,
	.core_reset, .osc_enable, .port_latch_set, .wdt_interval, .trim, .pin_float_mode, .port_oe_n,
	.strobe_pullup_en, .reset_pin_oe_n, .external_access_pin_oe_n);
`default_nettype wire

//--- testbench/reset_and_pin_float_control_bench.sv
// self-checking bench for the reset and pin-float controller
`timescale 1ns/100ps
`default_nettype none
module reset_and_pin_float_control_bench;
	import rpf_pkg::*;
	localparam int PD = 16;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, lerr, reset_pin, ale_pin, program_store_strobe;
	logic [2:0] port2_hi_pins;
	logic power_fail = 0, battery_lost = 0, wdt_timeout = 0, stop_mode = 0;
	logic rst_req = 0, flt_req = 0, p2_low = 0;
	logic core_reset, pc_load_zero, osc_enable, port_latch_set, test_mode, pin_float_mode;
	logic port_oe_n, reset_pin_oe_n, external_access_pin_oe_n, strobe_pullup_en;
	logic [1:0] wdt_interval;
	logic [7:0] trim;
	int err_total = 0, num_checks = 0, cyc = 0;
	always #2.5 pclk = ~pclk;
	rpf_board u_board (.rst_req, .flt_req, .p2_low, .reset_pin, .ale_pin, .program_store_strobe, .port2_hi_pins);
	rpf_ctrl #(.POR_DELAY(PD)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .reset_pin, .ale_pin, .program_store_strobe, .port2_hi_pins, .power_fail,
		.battery_lost, .wdt_timeout, .stop_mode, .core_reset, .pc_load_zero, .osc_enable, .port_latch_set,
		.wdt_interval, .trim, .test_mode, .pin_float_mode, .port_oe_n, .reset_pin_oe_n,
		.external_access_pin_oe_n, .strobe_pullup_en);
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		// no wait limit here: only the bench timeout ends a stalled transfer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		lerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wfor(input logic v);
		int n;
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (core_reset !== v && n < 300);
		chk(core_reset, v);
	endtask : wfor
	task automatic t_por;
		apb(0, OFS_TRIM, 0);
		chk(rd, 32'h65);
		apb(0, OFS_WDCTL, 0);
		chk(rd, 32'h40);
		wfor(0);
		chk(pc_load_zero, 1);
		apb(0, 8'h10, 0);
		chk(lerr, 1);
		chk(rd, 0);
		$display("power-up done");
	endtask : t_por
	task automatic t_wdog;
		int n;
		apb(1, OFS_WDCTL, 32'h2);
		apb(1, OFS_WDSEL, 32'h3);
		apb(0, OFS_WDSEL, 0);
		chk(rd, 3);
		wdt_timeout <= 1;
		@(posedge pclk);
		wdt_timeout <= 0;
		wfor(1);
		n = 0;
		while (core_reset === 1'b1 && n < 50)
		begin
			n++;
			@(negedge pclk);
		end
		chk(n, 8);
		chk(pc_load_zero, 1);
		apb(0, OFS_WDCTL, 0);
		chk(rd, 32'h6);
		apb(0, OFS_WDSEL, 0);
		chk(rd, 0);
		apb(1, OFS_WDCTL, 0);
		apb(0, OFS_WDCTL, 0);
		chk(rd, 0);
		wdt_timeout <= 1;
		@(posedge pclk);
		wdt_timeout <= 0;
		repeat (12) @(posedge pclk);
		chk(core_reset, 0);
		apb(0, OFS_WDCTL, 0);
		chk(rd, 0);
		$display("watchdog done");
	endtask : t_wdog
	task automatic t_ext;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge pclk);
			p2_low <= (i == 0);
			rst_req <= 1;
			wfor(1);
			repeat (20) @(posedge pclk);
			chk(core_reset, 1);
			rst_req <= 0;
			wfor(0);
			chk({pc_load_zero, test_mode}, {1'b1, i == 0});
			@(posedge pclk);
			p2_low <= 0;
			apb(0, OFS_WDCTL, 0);
			chk(rd, 0);
			chk(test_mode, i == 0);
		end
		rst_req <= 1;
		repeat (4) @(posedge pclk);
		rst_req <= 0;
		repeat (14) @(posedge pclk);
		chk(core_reset, 0);
		$display("pin reset done");
	endtask : t_ext
	task automatic t_flt;
		@(posedge pclk);
		flt_req <= 1;
		rst_req <= 1;
		wfor(1);
		@(posedge pclk);
		rst_req <= 0;
		repeat (14) @(posedge pclk);
		flt_req <= 0;
		repeat (6) @(negedge pclk);
		chk({pin_float_mode, port_oe_n, strobe_pullup_en, osc_enable}, 4'hF);
		apb(0, OFS_STATUS, 0);
		chk(rd[1:0], 2'h3);
		rst_req <= 1;
		repeat (20) @(posedge pclk);
		rst_req <= 0;
		wfor(0);
		chk(pin_float_mode, 0);
		$display("float done");
	endtask : t_flt
	task automatic t_stop;
		int n;
		@(posedge pclk);
		stop_mode <= 1;
		rst_req <= 1;
		wfor(1);
		chk({pc_load_zero, osc_enable}, 2'h3);
		@(posedge pclk);
		stop_mode <= 0;
		rst_req <= 0;
		n = 0;
		while (core_reset === 1'b1 && n < 300)
		begin
			n++;
			@(negedge pclk);
		end
		chk(n >= PD && n <= PD + 4, 1);
		$display("stop wake done");
	endtask : t_stop
	task automatic t_pwr;
		apb(1, OFS_TRIM, 32'h5A);
		power_fail <= 1;
		wfor(1);
		@(posedge pclk);
		power_fail <= 0;
		wfor(0);
		apb(0, OFS_WDCTL, 0);
		chk(rd[6], 1);
		apb(0, OFS_TRIM, 0);
		chk(rd, 32'h5A);
		battery_lost <= 1;
		repeat (6) @(posedge pclk);
		battery_lost <= 0;
		apb(0, OFS_TRIM, 0);
		chk(rd, 32'h65);
		$display("power done");
	endtask : t_pwr
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			conclude();
		end
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_por();
		t_wdog();
		t_ext();
		t_flt();
		t_stop();
		t_pwr();
		conclude();
	end
endmodule : reset_and_pin_float_control_bench
`default_nettype wire
